// file: udb_bias_core.sv
// up/down bias of the frequency reference and multi-function input decoding
// assumes freq_ref and freq_out come from the control loop on core_clk,
// contact inputs are asynchronous, registers over classic wishbone
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "udb_regs.svh"
module udb_bias_core
   import udb_pkg::*;
#(
   parameter int          NUM_IN      = 7,
   parameter int unsigned SAVE_CYCLES = `UDB_SAVE_TIME_S * `UDB_CLK_HZ,
   parameter int unsigned RAMP_CYCLES = (`UDB_RAMP_TIME_US * (`UDB_CLK_HZ / 1000000))
)
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [NUM_IN-1:0] din_i,
   input  wire udb_freq_t         freq_ref_i,
   input  wire udb_freq_t         freq_out_i,
   output udb_bias_t              bias_o,
   output udb_freq_t              freq_cmd_o,
   output logic                   fold_valid_o,
   output udb_freq_t              fold_ref_o,
   output logic                   keb2_o,
   output logic                   scb_o,
   output logic                   fb_rev_o,
   output logic      [6:0]        ulp_din_o,
   output logic                   ulp_disable_o,
   output logic                   bias_frozen_o
);
   logic [NUM_IN-1:0] din_s;
   udb_func_t         func_q [NUM_IN];
   logic [31:0]       ctrl_q;
   logic [15:0]       step_q;
   udb_bias_t         upper_q;
   udb_bias_t         lower_q;
   logic [15:0]       chg_limit_q;
   udb_bias_t         saved_q;
   udb_bias_t         bias_q;
   udb_bias_t         bias_d;
   udb_freq_t         ref_prev_q;
   logic              up_prev_q;
   logic              dn_prev_q;
   logic              frozen_q;
   logic [31:0]       ramp_cnt_q;
   logic [31:0]       save_cnt_q;
   logic              save_done_q;
   logic              wb_req;
   logic              wr_en;
   logic              pair_ok;
   logic              up_req;
   logic              dn_req;
   logic              ramp_tick;
   logic              ref_chg;
   logic              save_fire;
   logic              mstep;
   logic [15:0]       ref_delta;
   logic [31:0]       rd_data;
   logic [31:0]       status;

   // ==========================================================================
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic fn_closed(input udb_func_t code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_IN; i++)
         r = r | ((func_q[i] == code) & din_s[i]);
      return r;
   endfunction

   function automatic logic fn_open(input udb_func_t code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_IN; i++)
         r = r | ((func_q[i] == code) & ~din_s[i]);
      return r;
   endfunction

   function automatic udb_bias_t clamp(input logic signed [17:0] v,
                                       input udb_bias_t hi, input udb_bias_t lo);
      udb_bias_t r;
      r = v[15:0];
      if (v > 18'(signed'(hi)))
         r = hi;
      else if (v < 18'(signed'(lo)))
         r = lo;
      return r;
   endfunction

   function automatic udb_freq_t sat_add(input udb_freq_t f, input udb_bias_t b);
      logic signed [17:0] s;
      udb_freq_t          r;
      s = 18'(signed'({2'b00, f})) + 18'(signed'(b));
      r = s[15:0];
      if (s < 18'sh0)
         r = 16'h0000;
      else if (s > 18'sh0FFFF)
         r = 16'hFFFF;
      return r;
   endfunction

   // ==========================================================================
   // contact inputs
   udb_sync #(.W(NUM_IN)) u_sync
   (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pin_i    (din_i),
      .lvl_o    (din_s)
   );

   // ==========================================================================
   // wishbone slave
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en  = wb_req & wb_we_i;

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         ctrl_q      <= `UDB_RST_CTRL;
         step_q      <= `UDB_RST_STEP;
         upper_q     <= `UDB_RST_UPPER;
         lower_q     <= `UDB_RST_LOWER;
         chg_limit_q <= `UDB_RST_CHG_LIMIT;
      end
      else if (wr_en)
      begin
         unique case (wb_adr_i & 8'hFC)
            `UDB_OFS_CTRL:      ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_031F;
            `UDB_OFS_STEP:      step_q <= 16'(merge({16'h0, step_q}, wb_dat_i, wb_sel_i));
            `UDB_OFS_UPPER:     upper_q <= 16'(merge({16'h0, upper_q}, wb_dat_i, wb_sel_i));
            `UDB_OFS_LOWER:     lower_q <= 16'(merge({16'h0, lower_q}, wb_dat_i, wb_sel_i));
            `UDB_OFS_CHG_LIMIT: chg_limit_q <= 16'(merge({16'h0, chg_limit_q}, wb_dat_i,
                                                         wb_sel_i));
            default:            ;
         endcase
      end
   end

   generate
      for (genvar g = 0; g < NUM_IN; g++)
      begin : g_func
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
               func_q[g] <= `UDB_RST_FUNC;
            else if (wr_en && (wb_adr_i & 8'hFC) == 8'(`UDB_OFS_FUNC_BASE + 4 * g)
                     && wb_sel_i[0])
               func_q[g] <= wb_dat_i[7:0];
         end
      end
   endgenerate

   always_comb
   begin
      rd_data = 32'h0000_0000;
      unique case (wb_adr_i & 8'hFC)
         `UDB_OFS_CTRL:      rd_data = ctrl_q;
         `UDB_OFS_STEP:      rd_data = {16'h0000, step_q};
         `UDB_OFS_UPPER:     rd_data = {16'h0000, upper_q};
         `UDB_OFS_LOWER:     rd_data = {16'h0000, lower_q};
         `UDB_OFS_CHG_LIMIT: rd_data = {16'h0000, chg_limit_q};
         `UDB_OFS_SAVED:     rd_data = {16'h0000, saved_q};
         `UDB_OFS_BIAS:      rd_data = {16'h0000, bias_q};
         `UDB_OFS_STATUS:    rd_data = status;
         default:
         begin
            for (int i = 0; i < NUM_IN; i++)
            begin
               if ((wb_adr_i & 8'hFC) == 8'(`UDB_OFS_FUNC_BASE + 4 * i))
                  rd_data = {24'h000000, func_q[i]};
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         wb_dat_o <= 32'h0000_0000;
      else if (wb_req && !wb_we_i)
         wb_dat_o <= rd_data;
   end

   always_comb
   begin
      status                                    = 32'h0000_0000;
      status[`UDB_STAT_KEB2]                    = keb2_o;
      status[`UDB_STAT_SCB]                     = scb_o;
      status[`UDB_STAT_FBREV]                   = fb_rev_o;
      status[`UDB_STAT_ULPDIS]                  = ulp_disable_o;
      status[`UDB_STAT_FROZEN]                  = frozen_q;
      status[`UDB_STAT_PAIR]                    = pair_ok;
      status[`UDB_STAT_ULP_HI:`UDB_STAT_ULP_LO] = ulp_din_o;
   end

   // ==========================================================================
   // bias requests
   assign mstep     = ctrl_q[`UDB_CTRL_MSTEP];
   // a process, not an assign: the functions read the input table and levels
   always_comb
   begin
      pair_ok = (fn_closed(UDB_FN_UP) | fn_open(UDB_FN_UP))
              & (fn_closed(UDB_FN_DOWN) | fn_open(UDB_FN_DOWN));
      up_req  = pair_ok & fn_closed(UDB_FN_UP) & ~fn_closed(UDB_FN_DOWN);
      dn_req  = pair_ok & fn_closed(UDB_FN_DOWN) & ~fn_closed(UDB_FN_UP);
   end
   assign ramp_tick = (ramp_cnt_q == RAMP_CYCLES - 1);
   assign ref_chg   = (freq_ref_i != ref_prev_q);
   assign ref_delta = (freq_ref_i > ref_prev_q) ? freq_ref_i - ref_prev_q
                                                : ref_prev_q - freq_ref_i;
   assign save_fire = ctrl_q[`UDB_CTRL_SAVE] & ~save_done_q
                    & (save_cnt_q == SAVE_CYCLES - 1);

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         ramp_cnt_q <= 32'h0000_0000;
      else if (!(up_req | dn_req) || ramp_tick)
         ramp_cnt_q <= 32'h0000_0000;
      else
         ramp_cnt_q <= ramp_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         up_prev_q  <= 1'b0;
         dn_prev_q  <= 1'b0;
         ref_prev_q <= 16'h0000;
      end
      else
      begin
         up_prev_q  <= up_req;
         dn_prev_q  <= dn_req;
         ref_prev_q <= freq_ref_i;
      end
   end

   // ==========================================================================
   // freeze on large reference change, speed agree wins over set
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         frozen_q <= 1'b0;
      else if (!mstep && ref_delta > chg_limit_q && freq_out_i != freq_ref_i)
         frozen_q <= 1'b1;
      else if (mstep || freq_out_i == freq_ref_i)
         frozen_q <= 1'b0;
   end

   // ==========================================================================
   // next bias
   always_comb
   begin
      logic signed [17:0] sum;
      sum = 18'(signed'(bias_q));
      if (mstep && ref_chg)
         sum = 18'sh0;
      else if (mstep && save_fire)
         sum = 18'sh0;
      else if (frozen_q)
         sum = 18'(signed'(bias_q));
      else if (step_q == 16'h0000)
      begin
         if (up_req && ramp_tick)
            sum = sum + 18'sh1;
         else if (dn_req && ramp_tick)
            sum = sum - 18'sh1;
         else if (ctrl_q[`UDB_CTRL_MODE] && !up_req && !dn_req)
            sum = 18'sh0;
      end
      else
      begin
         if (up_req && !up_prev_q)
            sum = sum + 18'({2'b00, step_q});
         else if (dn_req && !dn_prev_q)
            sum = sum - 18'({2'b00, step_q});
      end
      bias_d = clamp(sum, upper_q, lower_q);
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         bias_q <= 16'sh0000;
      else
         bias_q <= bias_d;
   end

   // ==========================================================================
   // five second save
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         save_cnt_q  <= 32'h0000_0000;
         save_done_q <= 1'b0;
      end
      else if (bias_d != bias_q || (mstep && ref_chg))
      begin
         save_cnt_q  <= 32'h0000_0000;
         save_done_q <= 1'b0;
      end
      else if (save_fire)
         save_done_q <= 1'b1;
      else if (save_cnt_q != SAVE_CYCLES - 1)
         save_cnt_q <= save_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         saved_q <= 16'sh0000;
      else if (save_fire && !mstep)
         saved_q <= bias_q;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         fold_valid_o <= 1'b0;
         fold_ref_o   <= 16'h0000;
      end
      else
      begin
         fold_valid_o <= save_fire & mstep;
         if (save_fire && mstep)
            fold_ref_o <= sat_add(freq_ref_i, bias_q);
      end
   end

   // ==========================================================================
   // outputs to the control loop
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         freq_cmd_o    <= 16'h0000;
         keb2_o        <= 1'b0;
         scb_o         <= 1'b0;
         fb_rev_o      <= 1'b0;
         ulp_disable_o <= 1'b0;
      end
      else
      begin
         freq_cmd_o    <= sat_add(freq_ref_i, bias_d);
         keb2_o        <= fn_open(UDB_FN_KEB2_NC) | fn_closed(UDB_FN_KEB2_NO);
         scb_o         <= ctrl_q[`UDB_CTRL_PMOLV]
                        & (fn_closed(UDB_FN_SCB_NO) | fn_open(UDB_FN_SCB_NC));
         fb_rev_o      <= ctrl_q[`UDB_CTRL_PGVF] & fn_closed(UDB_FN_FB_DIR);
         ulp_disable_o <= (ctrl_q[`UDB_CTRL_PRG_HI:`UDB_CTRL_PRG_LO] == `UDB_PRG_ENABLED)
                        & fn_closed(UDB_FN_ULP_DIS);
      end
   end

   generate
      for (genvar k = 0; k < 7; k++)
      begin : g_ulp
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
               ulp_din_o[k] <= 1'b0;
            else
               ulp_din_o[k] <= fn_closed(8'(UDB_FN_ULP_IN1 + k));
         end
      end
   endgenerate

   assign bias_o        = bias_q;
   assign bias_frozen_o = frozen_q;
endmodule

// file: udb_regs.svh
// register offsets, field positions, reset values and timing figures of the bias block
// assumes a 32-bit classic wishbone slave decoding byte addresses on word boundaries
`ifndef UDB_REGS_SVH
`define UDB_REGS_SVH

// ==========================================================================
// register byte offsets
`define UDB_OFS_CTRL       8'h00
`define UDB_OFS_STEP       8'h04
`define UDB_OFS_UPPER      8'h08
`define UDB_OFS_LOWER      8'h0C
`define UDB_OFS_CHG_LIMIT  8'h10
`define UDB_OFS_SAVED      8'h14
`define UDB_OFS_BIAS       8'h18
`define UDB_OFS_STATUS     8'h1C
`define UDB_OFS_FUNC_BASE  8'h20

// ==========================================================================
// control register fields
`define UDB_CTRL_MODE      0
`define UDB_CTRL_SAVE      1
`define UDB_CTRL_MSTEP     2
`define UDB_CTRL_PMOLV     3
`define UDB_CTRL_PGVF      4
`define UDB_CTRL_PRG_LO    8
`define UDB_CTRL_PRG_HI    9

// ==========================================================================
// status register fields
`define UDB_STAT_KEB2      0
`define UDB_STAT_SCB       1
`define UDB_STAT_FBREV     2
`define UDB_STAT_ULPDIS    3
`define UDB_STAT_FROZEN    4
`define UDB_STAT_PAIR      5
`define UDB_STAT_ULP_LO    8
`define UDB_STAT_ULP_HI    14

// ==========================================================================
// reset values and the enabled program selection code
`define UDB_RST_CTRL       32'h0000_0000
`define UDB_RST_STEP       16'h0000
`define UDB_RST_UPPER      16'h7FFF
`define UDB_RST_LOWER      16'h8000
`define UDB_RST_CHG_LIMIT  16'h0000
`define UDB_RST_FUNC       8'h0F
`define UDB_PRG_ENABLED    2'h2

// ==========================================================================
// timing
`define UDB_CLK_HZ         250000000
`define UDB_SAVE_TIME_S    5
`define UDB_RAMP_TIME_US   1000

`endif

// file: udb_pkg.sv
// types shared by the bias and input function logic
// assumes the offsets and reset values come from udb_regs.svh
package udb_pkg;

   // ==========================================================================
   // data types
   typedef logic signed [15:0] udb_bias_t;
   typedef logic [15:0]        udb_freq_t;
   typedef logic [7:0]         udb_func_t;

   // ==========================================================================
   // input function codes
   typedef enum logic [7:0] {
      UDB_FN_UP      = 8'h75,
      UDB_FN_DOWN    = 8'h76,
      UDB_FN_KEB2_NC = 8'h7A,
      UDB_FN_KEB2_NO = 8'h7B,
      UDB_FN_SCB_NO  = 8'h7C,
      UDB_FN_SCB_NC  = 8'h7D,
      UDB_FN_FB_DIR  = 8'h7E,
      UDB_FN_ULP_IN1 = 8'h90,
      UDB_FN_ULP_DIS = 8'h9F
   } udb_fn_t;

endpackage

// file: udb_sync.sv
// three-stage contact input synchroniser with agreement filter
// assumes inputs are asynchronous to core_clk
`timescale 1ns/100ps
module udb_sync
#(
   parameter int W = 7
)
(
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] lvl_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ==========================================================================
   // chain and agreement
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_o <= '0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++)
         begin
            if (s2_q[i] == s3_q[i])
               lvl_o[i] <= s3_q[i];
         end
      end
   end
endmodule

// file: udb_contacts.sv
// contact model for the multi-function inputs of the bias block
// assumes the bench commands contact levels right after a clock edge
`timescale 1ns/100ps
module udb_contacts
(
   input  wire logic       core_clk,
   input  wire logic       slow,
   input  wire logic [6:0] want,
   output logic      [6:0] din
);
   int wait_n = 0;

   initial din = 7'h00;

   // ==========================================================================
   // contact motion
   // a slow contact settles a few cycles late and off the clock edge
   always @(posedge core_clk)
   begin
      if (want == din)
         wait_n <= 0;
      else if (wait_n < (slow ? 3 : 0))
         wait_n <= wait_n + 1;
      else
         din <= #1 want;
   end
endmodule

// file: udb_bias_chk.sv
// concurrent checks on the ports of the bias block
// assumes one clock domain; the control register is shadowed from bus writes
`timescale 1ns/100ps
module udb_bias_chk
   import udb_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire udb_freq_t   freq_ref_i,
   input wire udb_bias_t   bias_o,
   input wire udb_freq_t   freq_cmd_o,
   input wire logic        fold_valid_o,
   input wire logic        scb_o,
   input wire logic        ulp_disable_o,
   input wire logic        bias_frozen_o
);
   logic        [15:0] ctrl_q;
   logic        [15:0] ctrl_d;
   udb_freq_t          ref_q;
   logic signed [17:0] sum_w;
   udb_freq_t          cmd_w;

   // ==========================================================================
   // helper logic
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wb_sel_i[0]) ctrl_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_d[15:8] = wb_dat_i[15:8];
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         ctrl_q <= 16'h0000;
         ref_q <= 16'h0000;
      end
      else
      begin
         ref_q <= freq_ref_i;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00)
            ctrl_q <= ctrl_d;
      end
   end

   assign sum_w = $signed({2'b00, ref_q}) + bias_o;
   assign cmd_w = (sum_w < 0) ? 16'h0000 : (sum_w > 18'sh0FFFF) ? 16'hFFFF : sum_w[15:0];

   // ==========================================================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_cleared;
      ##[0:1] (bias_o == 16'sh0000);
   endsequence

   ack_after_req_a: assert property (s_take |=> s_pulse)
      else $error("ack missing or too long");
   ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
      else $error("ack without request");
   cmd_sum_a: assert property (freq_cmd_o == cmd_w)
      else $error("command is not reference plus bias");
   ref_clear_a: assert property ($changed(freq_ref_i) && ctrl_q[2] |-> ##1 s_cleared)
      else $error("bias kept over reference change");
   fold_clear_a: assert property (fold_valid_o |-> s_cleared)
      else $error("bias kept after fold");
   brake_gate_a: assert property (!ctrl_q[3] && !$past(ctrl_q[3]) |-> !scb_o)
      else $error("braking outside magnet vector mode");
   prog_gate_a: assert property (ctrl_q[9:8] != 2'h2 && $past(ctrl_q[9:8]) != 2'h2
                                 |-> !ulp_disable_o)
      else $error("program disable while selection differs");
   freeze_hold_a: assert property (bias_frozen_o && $past(bias_frozen_o)
                                   |-> $stable(bias_o))
      else $error("bias moved while frozen");
endmodule

bind udb_bias_core udb_bias_chk chk_u (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .freq_ref_i, .bias_o, .freq_cmd_o,
   .fold_valid_o, .scb_o, .ulp_disable_o, .bias_frozen_o);

// file: udb_bias_core_tb.sv
// self-checking bench for the bias and input function block
// assumes udb_contacts drives the inputs and registers answer over classic wishbone
`timescale 1ns/100ps
`include "udb_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module udb_bias_core_tb
   import udb_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic        cyc      = 1'b0;
   logic        stb      = 1'b0;
   logic        we       = 1'b0;
   logic  [7:0] adr      = 8'h00;
   logic [31:0] wdat     = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic        ack;
   logic  [6:0] want     = 7'h00;
   logic        slow     = 1'b0;
   logic  [6:0] din;
   udb_freq_t   fref     = 16'h0100;
   udb_freq_t   fout     = 16'h0100;
   udb_bias_t   bias;
   udb_freq_t   cmd;
   udb_freq_t   fold_ref;
   udb_freq_t   seen_ref;
   logic        fold_v;
   logic        seen     = 1'b0;
   logic  [3:0] flags;
   logic  [6:0] uldin;
   logic        frozen;
   int          n_mismatch = 0;
   int          compares   = 0;
   logic [31:0] rng      = 32'h0000_B97B;
   logic  [7:0] fc  [8]  = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h9F, 8'h7C, 8'h9F};
   logic [15:0] fcr [8]  = '{16'h0218, 16'h0218, 16'h0218, 16'h0218, 16'h0218, 16'h0218,
                             16'h0010, 16'h0118};

   always #2 core_clk = ~core_clk;

   udb_contacts ct_u (.core_clk(core_clk), .slow(slow), .want(want), .din(din));

   udb_bias_core #(.SAVE_CYCLES(50), .RAMP_CYCLES(4)) dut_u (
      .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .din_i(din), .freq_ref_i(fref), .freq_out_i(fout), .bias_o(bias), .freq_cmd_o(cmd),
      .fold_valid_o(fold_v), .fold_ref_o(fold_ref), .keb2_o(flags[0]), .scb_o(flags[1]),
      .fb_rev_o(flags[2]), .ulp_din_o(uldin), .ulp_disable_o(flags[3]),
      .bias_frozen_o(frozen));

   // ==========================================================================
   // helpers
   always @(posedge core_clk)
      if (fold_v === 1'b1 && !seen)
      begin
         seen <= 1'b1;
         seen_ref <= fold_ref;
      end

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic udb_freq_t sat(udb_freq_t r, udb_bias_t b);
      logic signed [17:0] s;
      s = $signed({2'b00, r}) + b;
      return (s < 0) ? 16'h0000 : (s > 18'sh0FFFF) ? 16'hFFFF : s[15:0];
   endfunction

   function automatic logic [10:0] fn_exp(logic [7:0] c, logic [15:0] cr, logic l);
      fn_exp[0] = (c == UDB_FN_KEB2_NC) ? !l : (c == UDB_FN_KEB2_NO) & l;
      fn_exp[1] = cr[3] & ((c == UDB_FN_SCB_NO) ? l : (c == UDB_FN_SCB_NC) & !l);
      fn_exp[2] = cr[4] & (c == UDB_FN_FB_DIR) & l;
      fn_exp[3] = (cr[9:8] == 2'h2) & (c == UDB_FN_ULP_DIS) & l;
      fn_exp[10:4] = (c[7:4] == 4'h9 && c[3:0] < 4'h7 && l) ? 7'h01 << c[2:0] : 7'h00;
   endfunction

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge core_clk);
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) n_mismatch++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 32'h0000_0000);
      `CHK(rd[15:0], e)
   endtask

   task automatic press(input logic [6:0] b, input int hold);
      @(posedge core_clk);
      slow <= ^rnd();
      want <= b;
      repeat (hold) @(posedge core_clk);
      want <= 7'h00;
      repeat (12) @(posedge core_clk);
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #120000;
      n_mismatch++;
      finish_test();
   end

   // ==========================================================================
   // scenarios
   initial
   begin
      udb_bias_t   s;
      logic [31:0] r;
      int          n;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      r = rnd();
      fref <= r[15:0];
      fout <= r[15:0];
      s = {12'h000, r[19:16] | 4'h1};
      rd_chk(`UDB_OFS_CTRL, 16'h0000);
      rd_chk(`UDB_OFS_UPPER, 16'h7FFF);
      rd_chk(`UDB_OFS_LOWER, 16'h8000);
      rd_chk(`UDB_OFS_FUNC_BASE, 16'h000F);
      rd_chk(8'hFC, 16'h0000);
      for (int i = 0; i < 15; i++)
      begin
         wb(1'b1, 8'h28, {24'h0, (i < 8) ? fc[i] : 8'h90 + 8'(i - 8)});
         wb(1'b1, `UDB_OFS_CTRL, {16'h0, (i < 8) ? fcr[i] : 16'h0218});
         for (int l = 0; l < 2; l++)
         begin
            want <= {4'h0, 1'(l), 2'b00};
            repeat (12) @(posedge core_clk);
            `CHK({uldin, flags}, fn_exp((i < 8) ? fc[i] : 8'h90 + 8'(i - 8),
                 (i < 8) ? fcr[i] : 16'h0218, 1'(l)))
         end
         want <= 7'h00;
      end
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0000);
      wb(1'b1, `UDB_OFS_STEP, {16'h0, s});
      wb(1'b1, `UDB_OFS_FUNC_BASE, {24'h0, UDB_FN_UP});
      press(7'h01, 10);
      `CHK(bias, 16'sh0000)
      wb(1'b1, 8'h24, {24'h0, UDB_FN_DOWN});
      press(7'h01, 10);
      `CHK(bias, s)
      `CHK(cmd, sat(fref, s))
      press(7'h01, 10);
      `CHK(bias, udb_bias_t'(2 * s))
      press(7'h03, 10);
      `CHK(bias, udb_bias_t'(2 * s))
      press(7'h02, 10);
      `CHK(bias, s)
      repeat (60) @(posedge core_clk);
      rd_chk(`UDB_OFS_SAVED, 16'h0000);
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0002);
      press(7'h01, 10);
      repeat (60) @(posedge core_clk);
      rd_chk(`UDB_OFS_SAVED, 16'(2 * s));
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0000);
      wb(1'b1, `UDB_OFS_CHG_LIMIT, 32'h0000_0010);
      fref <= fref + 16'h0100;
      repeat (4) @(posedge core_clk);
      `CHK(frozen, 1'b1)
      press(7'h01, 10);
      `CHK(bias, udb_bias_t'(2 * s))
      fout <= fref;
      repeat (4) @(posedge core_clk);
      `CHK(frozen, 1'b0)
      wb(1'b1, `UDB_OFS_STEP, 32'h0000_0000);
      wb(1'b1, `UDB_OFS_UPPER, 32'h0000_0003);
      wb(1'b1, `UDB_OFS_LOWER, 32'h0000_FFFE);
      press(7'h01, 60);
      `CHK(bias, 16'sh0003)
      press(7'h02, 80);
      `CHK(bias, -16'sh0002)
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge core_clk);
      `CHK(bias, 16'sh0000)
      want <= 7'h01;
      repeat (20) @(posedge core_clk);
      `CHK(bias > 16'sh0000, 1'b1)
      want <= 7'h00;
      repeat (12) @(posedge core_clk);
      `CHK(bias, 16'sh0000)
      wb(1'b1, `UDB_OFS_STEP, {16'h0, s});
      wb(1'b1, `UDB_OFS_UPPER, 32'h0000_7FFF);
      wb(1'b1, `UDB_OFS_LOWER, 32'h0000_8000);
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0004);
      press(7'h01, 10);
      `CHK(bias, s)
      r = rnd();
      fref <= r[15:0];
      repeat (4) @(posedge core_clk);
      `CHK(bias, 16'sh0000)
      wb(1'b1, `UDB_OFS_CTRL, 32'h0000_0006);
      press(7'h01, 10);
      n = 0;
      while (seen !== 1'b1 && n < 200)
      begin
         @(posedge core_clk);
         n++;
      end
      `CHK(seen, 1'b1)
      `CHK(seen_ref, sat(fref, s))
      `CHK(bias, 16'sh0000)
      finish_test();
   end
endmodule
